/* fpdl_dbg_model.sv */
// partner: external programmer with fuse key, memory data and erase completion
`timescale 1ns/1ps
module fpdl_dbg_model (
	// clock
	input wire logic pclk,
	// from the block
	input wire logic dbg_bus_en,
	input wire logic erase_start,
	// to the block
	output logic erase_done,
	output logic [7:0] dbg_rdata_mem,
	output logic [7:0] fuse_key
);
	logic [7:0] junk_r = 8'h00;
	logic [2:0] cnt_r = 3'h0;
	initial erase_done = 1'b0;
	initial fuse_key = 8'hc5;
	task automatic program_key(input logic [7:0] k);
		fuse_key <= k;
	endtask
	// memory byte only while the bus is enabled, a moving pattern otherwise
	assign dbg_rdata_mem = dbg_bus_en ? 8'h3c : junk_r;
	// erase finishes a few cycles after it starts
	always @(posedge pclk) begin
		junk_r <= junk_r + 8'h5b;
		erase_done <= (cnt_r == 3'h1);
		if (erase_start)
			cnt_r <= 3'h6;
		else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
endmodule

/* fpdl_ms_timer.sv */
// file: start-up delay counter built from a 1 ms enable pulse
`timescale 1ns/1ps
module fpdl_ms_timer
	import fpdl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic start,
	input wire logic [FPDL_MS_TOTAL_W-1:0] total_ms,
	// status
	output logic done
);
	logic [FPDL_MS_CNT_W-1:0] div_r;
	logic [FPDL_MS_TOTAL_W-1:0] ms_r;
	logic run_r;
	logic done_r;
	wire ms_tick = run_r && (div_r == FPDL_MS_CNT_W'(FPDL_MS_CYCLES - 1));
	wire reached = (ms_r == total_ms);
	// divider giving a one-cycle pulse each millisecond, and the millisecond count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= '0;
			ms_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (start) begin
			div_r <= '0;
			ms_r <= '0;
			run_r <= 1'b1;
			done_r <= 1'b0;
		end else if (run_r) begin
			if (reached) begin
				run_r <= 1'b0;
				done_r <= 1'b1;
			end else if (ms_tick) begin
				div_r <= '0;
				ms_r <= ms_r + 1'b1;
			end else begin
				div_r <= div_r + 1'b1;
			end
		end
	end
	assign done = done_r;
endmodule

/* fpdl_pkg.sv */
// package: register map, fuse layout and timing constants for the fuse partition and debug lock block
package fpdl_pkg;
	// fuse register offsets: printed offsets are not multiples of four, so they are indices
	localparam logic [7:0] FPDL_IDX_STARTUP = 8'h06;
	localparam logic [7:0] FPDL_IDX_CODE_END = 8'h07;
	localparam logic [7:0] FPDL_IDX_BOOT_END = 8'h08;
	localparam logic [7:0] FPDL_IDX_KEY = 8'h0a;
	// block-own registers (indices)
	localparam logic [7:0] FPDL_IDX_STATUS = 8'h10;
	localparam logic [7:0] FPDL_IDX_ERASE = 8'h11;
	localparam logic [7:0] FPDL_IDX_BOUNDS = 8'h12;
	localparam int FPDL_WORD_SHIFT = 2;
	// key and field layout
	localparam logic [7:0] FPDL_OPEN_KEY = 8'hc5;
	localparam logic [7:0] FPDL_ZERO_BYTE = 8'h00;
	localparam int FPDL_DLY_W = 3;
	localparam logic [2:0] FPDL_DLY_MAX = 3'h7;
	// flash addressing: byte address width, 256-byte block shift
	localparam int FPDL_FADDR_W = 17;
	localparam int FPDL_BLOCK_SHIFT = 8;
	localparam logic [FPDL_FADDR_W-1:0] FPDL_FLASH_TOP_DEF = 17'h0c000;
	// erase command key written to the erase register
	localparam logic [7:0] FPDL_ERASE_CMD = 8'h5a;
	// timing: 1 ms base unit at 25 MHz
	localparam int FPDL_CLK_HZ = 25000000;
	localparam int FPDL_MS_UNIT = 1;
	localparam int FPDL_MS_CYCLES = FPDL_CLK_HZ / 1000 * FPDL_MS_UNIT;
	localparam int FPDL_MS_CNT_W = 15;
	localparam int FPDL_MS_TOTAL_W = 7;
	// debug-port target regions
	typedef enum logic [2:0] {
		FPDL_RG_SRAM = 3'h0,
		FPDL_RG_REGS = 3'h1,
		FPDL_RG_FLASH = 3'h2,
		FPDL_RG_EEPROM = 3'h3,
		FPDL_RG_USER_ROW = 3'h4,
		FPDL_RG_SIG_ROW = 3'h5,
		FPDL_RG_FUSE = 3'h6,
		FPDL_RG_CS = 3'h7
	} fpdl_region_t;
	// flash section classes
	typedef enum logic [1:0] {
		FPDL_SEC_BOOT = 2'h0,
		FPDL_SEC_CODE = 2'h1,
		FPDL_SEC_DATA = 2'h2
	} fpdl_sec_t;
	// start-up sequencer states, gray along the path
	typedef enum logic [1:0] {
		FPDL_ST_WAIT = 2'b00,
		FPDL_ST_RUN = 2'b01
	} fpdl_state_t;
endpackage

/* fpdl_tb.sv */
// bench: fuse decode, flash partition, debug lock filter and erase over apb
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import fpdl_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, code_run, cpu_grant, dbg_grant, dbg_bus_en, erase_start, erase_eeprom, locked, erase_done;
	logic [7:0] fuse_startup = 8'h00, fuse_application_code_end = 8'h00, fuse_boot_section_end = 8'h00, fuse_key, dbg_rdata_mem, dbg_rdata;
	logic fuse_keep_eeprom = 1'b1, cpu_req = 1'b0, cpu_write = 1'b0, dbg_req = 1'b0, dbg_write = 1'b0, dbg_fuse_cmd = 1'b0;
	logic [2:0] cpu_region = 3'h0, dbg_region = 3'h0, startup_delay_select;
	logic [FPDL_FADDR_W-1:0] part_addr = 17'h0, boot_section_end, application_code_end;
	logic [1:0] part_section;
	int err_count = 0, n_compared = 0;
	always #20 pclk = ~pclk;
	// device under test and programmer model
	fpdl_top fpdl_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .fuse_startup, .fuse_application_code_end, .fuse_boot_section_end, .fuse_key, .fuse_keep_eeprom,
		.flash_top(FPDL_FLASH_TOP_DEF), .code_run, .startup_delay_select, .part_addr, .part_section,
		.boot_section_end, .application_code_end, .cpu_req, .cpu_write, .cpu_region, .cpu_grant, .dbg_req,
		.dbg_write, .dbg_fuse_cmd, .dbg_region, .dbg_rdata_mem, .dbg_grant, .dbg_bus_en, .dbg_rdata,
		.dbg_erase_req(1'b0), .erase_done, .erase_start, .erase_eeprom, .locked);
	fpdl_dbg_model fpdl_dbg_model_i (.pclk, .dbg_bus_en, .erase_start, .erase_done, .dbg_rdata_mem, .fuse_key);
	// verdict and end of run
	task automatic test_done;
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// reset with a new set of fuse levels
	task automatic rst(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b, input logic [7:0] k);
		@(posedge pclk);
		presetn <= 1'b0;
		fuse_startup <= s;
		fuse_application_code_end <= a;
		fuse_boot_section_end <= b;
		fpdl_dbg_model_i.program_key(k);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er,
		input logic ee);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		`CHK(pready, 1'b1)
		if (!w)
			`CHK(prdata, er)
		`CHK(pslverr, ee)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// partition query
	task automatic part(input logic [FPDL_FADDR_W-1:0] a, input logic [1:0] sec);
		@(posedge pclk);
		part_addr <= a;
		@(posedge pclk);
		#1 `CHK(part_section, sec)
	endtask
	// cpu access request
	task automatic cpu(input logic w, input logic [2:0] rg, input logic g);
		@(posedge pclk);
		cpu_req <= 1'b1;
		cpu_write <= w;
		cpu_region <= rg;
		#1 `CHK(cpu_grant, g)
	endtask
	// debug port access, grant now and read data one edge later
	task automatic dbg(input logic w, input logic fc, input logic [2:0] rg, input logic g, input logic [7:0] d,
		input logic cd);
		@(posedge pclk);
		dbg_req <= 1'b1;
		dbg_write <= w;
		dbg_fuse_cmd <= fc;
		dbg_region <= rg;
		#1 `CHK(dbg_grant, g)
		@(posedge pclk);
		dbg_req <= 1'b0;
		#1 if (cd) `CHK(dbg_rdata, d)
	endtask
	// watchdog
	initial begin
		repeat (40000) @(posedge pclk);
		err_count++;
		test_done;
	end
	// test sequence
	initial begin
		rst(8'h00, 8'h04, 8'h02, 8'h3a);
		`CHK(locked, 1'b1)
		apb(1'b0, 12'h018, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h01c, 32'h0, 32'h04, 1'b0);
		apb(1'b0, 12'h020, 32'h0, 32'h02, 1'b0);
		apb(1'b0, 12'h028, 32'h0, 32'h3a, 1'b0);
		apb(1'b0, 12'h048, 32'h0, 32'h00040200, 1'b0);
		apb(1'b0, 12'h030, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h018, 32'h7, 32'h0, 1'b1);
		`CHK(code_run, 1'b1)
		`CHK(boot_section_end, 17'h00200)
		`CHK(application_code_end, 17'h00400)
		part(17'h001ff, FPDL_SEC_BOOT);
		part(17'h00200, FPDL_SEC_CODE);
		part(17'h00400, FPDL_SEC_DATA);
		for (int r = 0; r < 8; r++) begin
			cpu(1'b0, r[2:0], 1'b1);
			cpu(1'b1, r[2:0], r != 5 && r != 6);
			dbg(1'b0, 1'b0, r[2:0], 1'b1, 8'h00, r != 7);
			dbg(1'b1, 1'b0, r[2:0], 1'b0, 8'h00, 1'b0);
		end
		dbg(1'b1, 1'b1, 3'h4, 1'b1, 8'h00, 1'b0);
		dbg(1'b1, 1'b1, 3'h0, 1'b0, 8'h00, 1'b0);
		apb(1'b1, 12'h044, 32'h5a, 32'h0, 1'b0);
		@(posedge pclk);
		#1 `CHK(erase_eeprom, 1'b1)
		for (int i = 0; i < 40 && locked !== 1'b0; i++)
			@(posedge pclk);
		`CHK(locked, 1'b0)
		dbg(1'b0, 1'b0, 3'h2, 1'b1, 8'h3c, 1'b1);
		rst(8'h01, 8'h00, 8'h02, 8'hc5);
		`CHK(locked, 1'b0)
		part(17'h0bfff, FPDL_SEC_CODE);
		part(17'h00100, FPDL_SEC_BOOT);
		dbg(1'b1, 1'b0, 3'h5, 1'b0, 8'h00, 1'b0);
		dbg(1'b1, 1'b0, 3'h6, 1'b1, 8'h00, 1'b0);
		dbg(1'b0, 1'b0, 3'h4, 1'b1, 8'h3c, 1'b1);
		fpdl_dbg_model_i.program_key(8'h11);
		@(posedge pclk);
		fuse_application_code_end <= 8'h09;
		repeat (24000) @(posedge pclk);
		`CHK(locked, 1'b0)
		`CHK(startup_delay_select, 3'h1)
		`CHK(code_run, 1'b0)
		part(17'h00a00, FPDL_SEC_CODE);
		for (int i = 0; i < 2000 && code_run !== 1'b1; i++)
			@(posedge pclk);
		`CHK(code_run, 1'b1)
		apb(1'b1, 12'h044, 32'h5a, 32'h0, 1'b0);
		@(posedge pclk);
		#1 `CHK(erase_eeprom, 1'b0)
		rst(8'h00, 8'h04, 8'h00, 8'hc5);
		part(17'h08000, FPDL_SEC_BOOT);
		part(17'h00500, FPDL_SEC_BOOT);
		test_done;
	end
endmodule

/* fpdl_top.sv */
// file: fuse decode, flash partition, debug-port lock filter and APB register slave
// How it works
// - start-up delay 0..64 ms from code
// - application end fuse times 256 bytes
// - flash at or above both code end and boot end is data
// - zero app end means code to top
// - boot end fuse times 256 bytes
// - zero boot end makes all boot
// - open only when key equals C5
// - locked debug port sees only control space, and writes only the user row
// - cpu accesses never blocked by lock
// - unlocked debug full access, signature row read-only
// - locked debug denied except control-space read and user row write
// - denied reads return zero data
// - locked user row write-only via fuse command
// - unlock only through full device erase
// - locked erase always clears eeprom
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module fpdl_top
	import fpdl_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// raw fuse array values
	input wire logic [7:0] fuse_startup,
	input wire logic [7:0] fuse_application_code_end,
	input wire logic [7:0] fuse_boot_section_end,
	input wire logic [7:0] fuse_key,
	input wire logic fuse_keep_eeprom,
	input wire logic [FPDL_FADDR_W-1:0] flash_top,
	// start-up
	output logic code_run,
	output logic [FPDL_DLY_W-1:0] startup_delay_select,
	// flash partition query
	input wire logic [FPDL_FADDR_W-1:0] part_addr,
	output logic [1:0] part_section,
	output logic [FPDL_FADDR_W-1:0] boot_section_end,
	output logic [FPDL_FADDR_W-1:0] application_code_end,
	// cpu access request (bypasses the lock filter)
	input wire logic cpu_req,
	input wire logic cpu_write,
	input wire logic [2:0] cpu_region,
	output logic cpu_grant,
	// debug programming port request
	input wire logic dbg_req,
	input wire logic dbg_write,
	input wire logic dbg_fuse_cmd,
	input wire logic [2:0] dbg_region,
	input wire logic [7:0] dbg_rdata_mem,
	output logic dbg_grant,
	output logic dbg_bus_en,
	output logic [7:0] dbg_rdata,
	// full device erase
	input wire logic dbg_erase_req,
	input wire logic erase_done,
	output logic erase_start,
	output logic erase_eeprom,
	output logic locked
);
	logic [7:0] dly_r, app_r, boot_r, key_r;
	logic keep_ee_r;
	logic run_started;
	logic capt_r;
	logic lock_r;
	logic erasing_r;
	logic ee_r;
	logic [7:0] drd_r;
	logic [31:0] prdata_r;
	fpdl_state_t st_r, st_nxt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capt_r <= 1'b0;
			dly_r <= FPDL_ZERO_BYTE;
			app_r <= FPDL_ZERO_BYTE;
			boot_r <= FPDL_ZERO_BYTE;
			key_r <= FPDL_ZERO_BYTE;
			keep_ee_r <= 1'b0;
		end else if (!capt_r) begin
			capt_r <= 1'b1;
			dly_r <= fuse_startup;
			app_r <= fuse_application_code_end;
			boot_r <= fuse_boot_section_end;
			key_r <= fuse_key;
			keep_ee_r <= fuse_keep_eeprom;
		end
	end

	wire key_open = (key_r == FPDL_OPEN_KEY);

	// lock state, erase is the only exit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= 1'b1;
		end else if (erasing_r && erase_done) begin
			lock_r <= 1'b0;
		end else if (capt_r && !erasing_r && st_r == FPDL_ST_WAIT && !run_started) begin
			lock_r <= !key_open;
		end
	end

	// start-up sequencer
	logic timer_done;
	logic timer_start;
	assign timer_start = capt_r && !run_started;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_started <= 1'b0;
			st_r <= FPDL_ST_WAIT;
		end else begin
			if (capt_r) begin
				run_started <= 1'b1;
			end
			st_r <= st_nxt;
		end
	end
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			FPDL_ST_WAIT: begin
				if (run_started && timer_done) begin
					st_nxt = FPDL_ST_RUN;
				end
			end
			FPDL_ST_RUN: begin
				st_nxt = FPDL_ST_RUN;
			end
			default: begin
				st_nxt = FPDL_ST_WAIT;
			end
		endcase
	end

	wire [2:0] dly_code = dly_r[FPDL_DLY_W-1:0];
	wire [FPDL_MS_TOTAL_W-1:0] dly_ms = (dly_code == 3'h0) ? '0 :
		FPDL_MS_TOTAL_W'(7'h01 << (dly_code - 3'h1));
	fpdl_ms_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(timer_start),
		.total_ms(dly_ms),
		.done(timer_done)
	);
	assign code_run = (st_r == FPDL_ST_RUN);
	assign startup_delay_select = dly_code;

	wire [FPDL_FADDR_W-1:0] boot_b = {1'b0, boot_r, 8'h00};
	wire [FPDL_FADDR_W-1:0] boot_end_w = (boot_r == FPDL_ZERO_BYTE) ? flash_top : boot_b;
	wire [FPDL_FADDR_W-1:0] app_b = {1'b0, app_r, 8'h00};
	wire [FPDL_FADDR_W-1:0] app_end_w = (app_r == FPDL_ZERO_BYTE) ? flash_top : app_b;
	assign boot_section_end = boot_end_w;
	assign application_code_end = app_end_w;
	assign part_section = (part_addr < boot_end_w) ? FPDL_SEC_BOOT :
		(part_addr < app_end_w) ? FPDL_SEC_CODE : FPDL_SEC_DATA;

	// cpu grant, signature row and fuses read-only
	wire cpu_ro = (cpu_region == FPDL_RG_SIG_ROW) || (cpu_region == FPDL_RG_FUSE);
	assign cpu_grant = cpu_req && !(cpu_write && cpu_ro);

	wire dbg_open_ok = !(dbg_write && dbg_region == FPDL_RG_SIG_ROW);
	wire dbg_lock_ok = (dbg_region == FPDL_RG_CS && !dbg_write) ||
		(dbg_region == FPDL_RG_USER_ROW && dbg_write && dbg_fuse_cmd);
	wire dbg_ok = lock_r ? dbg_lock_ok : dbg_open_ok;
	// read completes even when denied
	assign dbg_grant = dbg_req && (dbg_ok || !dbg_write);
	assign dbg_bus_en = dbg_req && dbg_ok && !(lock_r && dbg_region == FPDL_RG_CS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drd_r <= FPDL_ZERO_BYTE;
		end else if (dbg_req && !dbg_write) begin
			drd_r <= dbg_ok ? dbg_rdata_mem : FPDL_ZERO_BYTE;
		end
	end
	assign dbg_rdata = drd_r;

	// apb decode
	wire [31:0] sw_erase = {24'h000000, FPDL_ERASE_CMD};
	wire [9:0] widx = paddr[11:FPDL_WORD_SHIFT];
	wire sel_dly = (widx == 10'(FPDL_IDX_STARTUP));
	wire sel_app = (widx == 10'(FPDL_IDX_CODE_END));
	wire sel_boot = (widx == 10'(FPDL_IDX_BOOT_END));
	wire sel_key = (widx == 10'(FPDL_IDX_KEY));
	wire sel_stat = (widx == 10'(FPDL_IDX_STATUS));
	wire sel_erase = (widx == 10'(FPDL_IDX_ERASE));
	wire sel_bnd = (widx == 10'(FPDL_IDX_BOUNDS));
	wire mapped = sel_dly | sel_app | sel_boot | sel_key | sel_stat | sel_erase | sel_bnd;
	wire apb_acc = psel && penable;
	wire apb_wr_erase = apb_acc && pwrite && sel_erase && pstrb[0] && (pwdata == sw_erase);
	wire bad_wr = pwrite && !sel_erase;

	wire erase_go = (dbg_erase_req || apb_wr_erase) && !erasing_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erasing_r <= 1'b0;
			ee_r <= 1'b0;
		end else if (erase_go) begin
			erasing_r <= 1'b1;
			ee_r <= lock_r || !keep_ee_r;
		end else if (erasing_r && erase_done) begin
			erasing_r <= 1'b0;
		end
	end
	assign erase_start = erase_go;
	assign erase_eeprom = ee_r;
	assign locked = lock_r;

	// read mux
	wire [31:0] stat_w = {26'h0, erasing_r, ee_r, code_run, key_open, capt_r, lock_r};
	wire [31:0] bnd_w = {8'h00, app_r, boot_r, 8'h00};
	wire [31:0] rd_w = sel_dly ? {24'h0, dly_r} :
		sel_app ? {24'h0, app_r} :
		sel_boot ? {24'h0, boot_r} :
		sel_key ? {24'h0, key_r} :
		sel_stat ? stat_w :
		sel_bnd ? bnd_w : 32'h00000000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_w;
		end
	end
	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = apb_acc && (!mapped || bad_wr);

	// assertions
	AST_KEY_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(capt_r) |=> (lock_r == (key_r != FPDL_OPEN_KEY)))
		else $error("lock state does not follow key");
	AST_LOCK_STAYS: assert property (@(posedge pclk) disable iff (!presetn)
		capt_r && $past(run_started) && $fell(lock_r) |-> $past(erasing_r && erase_done))
		else $error("lock left without erase");
	AST_EE_FORCED: assert property (@(posedge pclk) disable iff (!presetn)
		erase_go && lock_r |=> ee_r)
		else $error("locked erase kept eeprom");
	AST_DBG_DENY: assert property (@(posedge pclk) disable iff (!presetn)
		lock_r && dbg_req && dbg_region != FPDL_RG_USER_ROW && dbg_region != FPDL_RG_CS |-> !dbg_bus_en)
		else $error("locked debug reached memory");
	AST_MASK_RD: assert property (@(posedge pclk) disable iff (!presetn)
		lock_r && dbg_req && !dbg_write && dbg_region != FPDL_RG_CS |=> dbg_rdata == FPDL_ZERO_BYTE)
		else $error("denied read leaked data");
	AST_CPU_FREE: assert property (@(posedge pclk) disable iff (!presetn)
		cpu_req && !cpu_write |-> cpu_grant)
		else $error("cpu read blocked");
	AST_BOOT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		capt_r && boot_r == FPDL_ZERO_BYTE && part_addr < flash_top |-> part_section == FPDL_SEC_BOOT)
		else $error("zero boot end not all boot");
	AST_DATA_SEC: assert property (@(posedge pclk) disable iff (!presetn)
		capt_r && part_addr >= app_end_w && part_addr >= boot_end_w |-> part_section == FPDL_SEC_DATA)
		else $error("data section misclassified");
	AST_DLY_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(capt_r) && fuse_startup[2:0] == 3'h0 |-> ##[1:6] code_run)
		else $error("zero delay start too slow");
	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		capt_r && $past(capt_r) |-> $stable(boot_r) && $stable(app_r) && $stable(dly_r))
		else $error("captured fuse changed");
endmodule
